// [ccs_pkg.sv]
// ****************************************************************
// Clock and calibration sequencer constants
// ****************************************************************
package ccs_pkg;

  // ****************************************************************
  // Register offsets (7-bit address space)
  // ****************************************************************
  localparam logic [6:0] ADDR_CAL_DIV = 7'h01;
  localparam logic [6:0] ADDR_GATE = 7'h02;
  localparam logic [6:0] ADDR_PULLUP = 7'h4F;
  localparam logic [6:0] ADDR_LO_CLK = 7'h51;
  localparam logic [6:0] ADDR_LO_DIV = 7'h52;
  localparam logic [6:0] ADDR_CM = 7'h53;
  localparam logic [6:0] ADDR_BIAS = 7'h58;
  localparam logic [6:0] ADDR_GAIN = 7'h5E;
  localparam logic [6:0] ADDR_PHASE = 7'h5F;
  localparam logic [6:0] ADDR_TERM = 7'h7B;
  localparam logic [6:0] ADDR_STATUS = 7'h7C;
  localparam logic [6:0] ADDR_OFFCAL = 7'h7D;
  localparam logic [6:0] ADDR_CAL_CTRL = 7'h7E;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned CAL_DIV_LSB = 0;
  localparam int unsigned GATE_BIT = 10;
  localparam int unsigned PULLUP_EN_BIT = 6;
  localparam int unsigned SRC_SEL_BIT = 0;
  localparam int unsigned DIV_EN_LSB = 6;
  localparam int unsigned DIV_A_LSB = 3;
  localparam int unsigned DIV_B_LSB = 0;
  localparam int unsigned CM_LSB = 9;
  localparam int unsigned PULLUP_STR_LSB = 13;
  localparam int unsigned BIAS_LSB = 0;
  localparam int unsigned I_GAIN_LSB = 0;
  localparam int unsigned Q_GAIN_LSB = 8;
  localparam int unsigned PH_MAG_LSB = 9;
  localparam int unsigned PH_POL_BIT = 15;
  localparam int unsigned PH_WIDE_BIT = 15;
  localparam int unsigned FSM_CLR_BIT = 8;
  localparam int unsigned TERM_LSB = 0;
  localparam int unsigned OC_DIV_LSB = 0;
  localparam int unsigned I_EN_BIT = 8;
  localparam int unsigned Q_EN_BIT = 9;
  localparam int unsigned DOUBLER_BIT = 10;
  localparam int unsigned MULTIPLIER_LSB = 11;

  // ****************************************************************
  // Reset values and codes
  // ****************************************************************
  localparam logic [15:0] RST_CAL_DIV = 16'h0808;
  localparam logic [15:0] RST_GATE = 16'h0500;
  localparam logic [1:0] DIV_EN_ON = 2'h3;
  localparam logic [4:0] MULTIPLIER_ONE = 5'h01;
  localparam logic [15:0] CAL_STEPS = 16'h0040;

  typedef struct packed {
    logic we;
    logic re;
    logic [6:0] addr;
    logic [15:0] wdata;
  } ccs_regbus_t;

  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_RUN = 2'b01,
    CAL_DONE = 2'b10
  } ccs_cal_state_t;

  typedef struct packed {
    ccs_cal_state_t st;
    logic [15:0] cnt;
  } ccs_cal_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } ccs_div_state_t;

  function automatic logic [15:0] ccs_pow2(input logic [2:0] e);
    ccs_pow2 = 16'h0001 << e;
  endfunction

  function automatic logic [15:0] ccs_div_a(input logic [2:0] code);
    unique case (code)
      3'b000: ccs_div_a = 16'h0001;
      3'b001: ccs_div_a = 16'h0002;
      3'b011: ccs_div_a = 16'h0004;
      3'b111: ccs_div_a = 16'h0008;
      default: ccs_div_a = 16'h0010;
    endcase
  endfunction

endpackage

// [ccs_tick_div.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Tick divider: one output tick per divisor input ticks
// ****************************************************************
module ccs_tick_div
  import ccs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic en,
  input wire logic in_tick,
  input wire logic [15:0] divisor,
  output logic out_tick
);

  ccs_div_state_t q;
  ccs_div_state_t d;

  // Divisor of zero stops the output rather than dividing by 65536
  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (!en) begin
      d.cnt = 16'h0000;
    end else if (in_tick && (divisor != 16'h0000)) begin
      if (q.cnt >= divisor - 16'h0001) begin
        d.cnt = 16'h0000;
        d.tick = 1'b1;
      end else begin
        d.cnt = q.cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign out_tick = q.tick;

endmodule // ccs_tick_div
`default_nettype wire

// [ccs_sequencer.sv]
// Behaviour
// - State-machine clock muxed from divided reference or divided LO.
// - Internal mode divides reference by two to exponent field.
// - Reg 82 bits 5:3 first stage, 2:0 second power-of-two stage.
// - First stage codes 0,1,3,7 give 1,2,4,8; others 16.
// - Source select bit one clocks state machine from divided LO.
// - Offset clock is state-machine clock over twice divider field.
// - I and Q offset correction run independently on own enables.
// - Phase trim magnitude bits 14:9, polarity bit 15 of reg 95.
// - Reg 126 bit 15 selects fine or wide phase trim.
// - Gain trim: I in reg 94 bits 7:0, Q in 15:8.
// - Reg 123 bits 1:0 select LO port termination.
// - Inherent sync flagged when VCO multiple, no doubler, multiplier 1.
// - Frames carry read/write, 7-bit address and 16 data bits.
//
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module ccs_sequencer
  import ccs_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire ccs_regbus_t bus,
  output logic [15:0] rdata,
  input wire logic reference_input_tick,
  input wire logic lo_input_tick,
  input wire logic vco_ref_multiple,
  output logic state_machine_clock_tick,
  output logic offset_cal_clock_tick,
  output logic i_cal_busy,
  output logic q_cal_busy,
  output logic i_cal_done,
  output logic q_cal_done,
  output logic [7:0] i_gain_trim,
  output logic [7:0] q_gain_trim,
  output logic [5:0] phase_trim_magnitude,
  output logic phase_trim_polarity,
  output logic phase_trim_wide_range,
  output logic [3:0] common_mode_select,
  output logic if_amp_pullup_enable,
  output logic [2:0] if_amp_pullup_strength,
  output logic [1:0] if_amp_bias_config,
  output logic [1:0] lo_port_termination,
  output logic inherent_sync
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [127:0][15:0] regs;
    logic [15:0] rdata;
    logic sm_tick;
    ccs_cal_t i_cal;
    ccs_cal_t q_cal;
    logic i_busy;
    logic i_done;
    logic q_busy;
    logic q_done;
    logic sync;
  } ccs_top_state_t;

  ccs_top_state_t q;
  ccs_top_state_t d;

  logic int_tick;
  logic ext_a_tick;
  logic ext_b_tick;
  logic oc_tick;
  logic ext_en;
  logic int_gate;
  logic src_sel;
  logic [15:0] int_div;
  logic [15:0] ext_a_div;
  logic [15:0] ext_b_div;
  logic [15:0] oc_div;
  logic [15:0] status;

  function automatic ccs_cal_t cal_next(input ccs_cal_t cur,
                                        input logic en,
                                        input logic clr,
                                        input logic tick);
    ccs_cal_t nxt;
    nxt = cur;
    if (clr || !en) begin
      nxt.st = CAL_IDLE;
      nxt.cnt = 16'h0000;
    end else begin
      unique case (cur.st)
        CAL_IDLE: begin
          nxt.st = CAL_RUN;
          nxt.cnt = 16'h0000;
        end
        CAL_RUN: begin
          if (tick) begin
            if (cur.cnt >= CAL_STEPS - 16'h0001) begin
              nxt.st = CAL_DONE;
            end else begin
              nxt.cnt = cur.cnt + 16'h0001;
            end
          end
        end
        CAL_DONE: begin
          nxt.st = CAL_DONE;
        end
        default: begin
          nxt.st = CAL_IDLE;
        end
      endcase
    end
    return nxt;
  endfunction

  // ****************************************************************
  // Clock dividers
  // ****************************************************************
  assign src_sel = q.regs[ADDR_LO_CLK][SRC_SEL_BIT];
  assign int_gate = q.regs[ADDR_GATE][GATE_BIT];
  // Only the full enable code opens the LO path
  assign ext_en = (q.regs[ADDR_LO_CLK][DIV_EN_LSB +: 2] == DIV_EN_ON);
  assign int_div = ccs_pow2(q.regs[ADDR_CAL_DIV][CAL_DIV_LSB +: 3]);
  assign ext_a_div = ccs_div_a(q.regs[ADDR_LO_DIV][DIV_A_LSB +: 3]);
  assign ext_b_div = ccs_pow2(q.regs[ADDR_LO_DIV][DIV_B_LSB +: 3]);
  assign oc_div = {7'h00, q.regs[ADDR_OFFCAL][OC_DIV_LSB +: 8], 1'b0};

  ccs_tick_div u_int_div (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .en(int_gate),
    .in_tick(reference_input_tick),
    .divisor(int_div),
    .out_tick(int_tick)
  );

  ccs_tick_div u_ext_a_div (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .en(ext_en),
    .in_tick(lo_input_tick),
    .divisor(ext_a_div),
    .out_tick(ext_a_tick)
  );

  ccs_tick_div u_ext_b_div (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .en(ext_en),
    .in_tick(ext_a_tick),
    .divisor(ext_b_div),
    .out_tick(ext_b_tick)
  );

  ccs_tick_div u_oc_div (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .en(1'b1),
    .in_tick(q.sm_tick),
    .divisor(oc_div),
    .out_tick(oc_tick)
  );

  assign status = {9'h000, q.sync, q.q_done, q.i_done, q.q_busy, q.i_busy,
                   ext_en, src_sel};

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    d = q;
    if (bus.we && (bus.addr != ADDR_STATUS)) begin
      d.regs[bus.addr] = bus.wdata;
    end
    d.rdata = 16'h0000;
    if (bus.re) begin
      d.rdata = (bus.addr == ADDR_STATUS) ? status : q.regs[bus.addr];
    end
    d.sm_tick = src_sel ? ext_b_tick : int_tick;
    d.i_cal = cal_next(q.i_cal, q.regs[ADDR_OFFCAL][I_EN_BIT],
                       q.regs[ADDR_CAL_CTRL][FSM_CLR_BIT], oc_tick);
    d.q_cal = cal_next(q.q_cal, q.regs[ADDR_OFFCAL][Q_EN_BIT],
                       q.regs[ADDR_CAL_CTRL][FSM_CLR_BIT], oc_tick);
    d.i_busy = (d.i_cal.st == CAL_RUN);
    d.i_done = (d.i_cal.st == CAL_DONE);
    d.q_busy = (d.q_cal.st == CAL_RUN);
    d.q_done = (d.q_cal.st == CAL_DONE);
    d.sync = vco_ref_multiple && !q.regs[ADDR_OFFCAL][DOUBLER_BIT] &&
             (q.regs[ADDR_OFFCAL][MULTIPLIER_LSB +: 5] == MULTIPLIER_ONE);
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
      q.regs[ADDR_CAL_DIV] <= RST_CAL_DIV;
      q.regs[ADDR_GATE] <= RST_GATE;
    end else begin
      q <= d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign rdata = q.rdata;
  assign state_machine_clock_tick = q.sm_tick;
  assign offset_cal_clock_tick = oc_tick;
  assign i_cal_busy = q.i_busy;
  assign q_cal_busy = q.q_busy;
  assign i_cal_done = q.i_done;
  assign q_cal_done = q.q_done;
  assign i_gain_trim = q.regs[ADDR_GAIN][I_GAIN_LSB +: 8];
  assign q_gain_trim = q.regs[ADDR_GAIN][Q_GAIN_LSB +: 8];
  assign phase_trim_magnitude = q.regs[ADDR_PHASE][PH_MAG_LSB +: 6];
  assign phase_trim_polarity = q.regs[ADDR_PHASE][PH_POL_BIT];
  assign phase_trim_wide_range = q.regs[ADDR_CAL_CTRL][PH_WIDE_BIT];
  assign common_mode_select = q.regs[ADDR_CM][CM_LSB +: 4];
  assign if_amp_pullup_enable = q.regs[ADDR_PULLUP][PULLUP_EN_BIT];
  assign if_amp_pullup_strength = q.regs[ADDR_CM][PULLUP_STR_LSB +: 3];
  assign if_amp_bias_config = q.regs[ADDR_BIAS][BIAS_LSB +: 2];
  assign lo_port_termination = q.regs[ADDR_TERM][TERM_LSB +: 2];
  assign inherent_sync = q.sync;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_src_mux;
    @(posedge sys_clk) disable iff (!reset_n)
    ##1 1'b1 |-> state_machine_clock_tick ==
      ($past(src_sel) ? $past(ext_b_tick) : $past(int_tick));
  endproperty
  a_src_mux: assert property (p_src_mux)
    else $error("state machine tick does not follow selected source");

  property p_ext_quiet;
    @(posedge sys_clk) disable iff (!reset_n)
    (!ext_en && $past(!ext_en)) ##1 !ext_en |-> !ext_b_tick;
  endproperty
  a_ext_quiet: assert property (p_ext_quiet)
    else $error("disabled LO divider produced an edge");

  property p_gate_off;
    @(posedge sys_clk) disable iff (!reset_n)
    (!int_gate && !src_sel) [*2] |=> !state_machine_clock_tick;
  endproperty
  a_gate_off: assert property (p_gate_off)
    else $error("gated internal path still ticks");

  property p_int_half;
    @(posedge sys_clk) disable iff (!reset_n)
    (int_tick && int_div == 16'h0002) |=> !int_tick;
  endproperty
  a_int_half: assert property (p_int_half)
    else $error("internal divide by two ticked twice in a row");

  property p_div_a_code;
    @(posedge sys_clk) disable iff (!reset_n)
    (q.regs[ADDR_LO_DIV][DIV_A_LSB +: 3] == 3'b010) |->
      ext_a_div == 16'h0010;
  endproperty
  a_div_a_code: assert property (p_div_a_code)
    else $error("first stage code 010 not divide by 16");

  property p_oc_div;
    @(posedge sys_clk) disable iff (!reset_n)
    (q.regs[ADDR_OFFCAL][OC_DIV_LSB +: 8] == 8'h03) |->
      oc_div == 16'h0006;
  endproperty
  a_oc_div: assert property (p_oc_div)
    else $error("offset clock divisor is not twice the field");

  property p_i_idle;
    @(posedge sys_clk) disable iff (!reset_n)
    !q.regs[ADDR_OFFCAL][I_EN_BIT] |=> (!i_cal_busy && !i_cal_done);
  endproperty
  a_i_idle: assert property (p_i_idle)
    else $error("I offset correction active while disabled");

  property p_q_indep;
    @(posedge sys_clk) disable iff (!reset_n)
    (q.regs[ADDR_OFFCAL][I_EN_BIT] && !q.regs[ADDR_OFFCAL][Q_EN_BIT] &&
     !q.regs[ADDR_CAL_CTRL][FSM_CLR_BIT] && !q.i_done && !q.i_busy)
      |=> (i_cal_busy && !q_cal_busy);
  endproperty
  a_q_indep: assert property (p_q_indep)
    else $error("I and Q offset correction not independent");

  property p_gain_wr;
    @(posedge sys_clk) disable iff (!reset_n)
    (bus.we && bus.addr == ADDR_GAIN) |=>
      (i_gain_trim == $past(bus.wdata[7:0]) &&
       q_gain_trim == $past(bus.wdata[15:8]));
  endproperty
  a_gain_wr: assert property (p_gain_wr)
    else $error("gain trim outputs do not follow write");

  property p_wr_rd;
    @(posedge sys_clk) disable iff (!reset_n)
    (bus.we && bus.addr != ADDR_STATUS) ##1
      (bus.re && !bus.we && bus.addr == $past(bus.addr))
      |=> rdata == $past(bus.wdata, 2);
  endproperty
  a_wr_rd: assert property (p_wr_rd)
    else $error("read back differs from written word");

  property p_sync;
    @(posedge sys_clk) disable iff (!reset_n)
    (!vco_ref_multiple) |=> !inherent_sync;
  endproperty
  a_sync: assert property (p_sync)
    else $error("sync flagged without VCO reference multiple");

endmodule // ccs_sequencer
`default_nettype wire

// [ccs_tick_source.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Far-side clock sources: reference input and external LO
// ****************************************************************
module ccs_tick_source (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic lo_present,
  input wire logic slow,
  output logic ref_tick,
  output logic lo_tick
);
  logic phase_q;

  // Slow mode gives one edge every second cycle
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_q <= 1'b0;
      ref_tick <= 1'b0;
      lo_tick <= 1'b0;
    end else begin
      phase_q <= ~phase_q;
      ref_tick <= slow ? phase_q : 1'b1;
      lo_tick <= lo_present;
    end
  end
endmodule // ccs_tick_source
`default_nettype wire

// [ccs_sequencer_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module ccs_sequencer_tb;
  import ccs_pkg::*;
  logic sys_clk;
  logic reset_n;
  ccs_regbus_t bus;
  logic [15:0] rdata;
  logic ref_tick, lo_tick, lo_present, slow, vco_ref_multiple, off_sel;
  logic sm_tick, off_tick, i_busy, q_busy, i_done, q_done;
  logic [7:0] i_gain, q_gain;
  logic [5:0] ph_mag;
  logic ph_pol, ph_wide, pu_en, sync_flag;
  logic [3:0] cm_sel;
  logic [2:0] pu_str;
  logic [1:0] bias, term;
  int fails, n_compared, cyc, seed, d, p, k;
  logic [15:0] v;
  wire tk = off_sel ? off_tick : sm_tick;

  ccs_tick_source i_ccs_tick_source (.sys_clk(sys_clk), .reset_n(reset_n),
    .lo_present(lo_present), .slow(slow), .ref_tick(ref_tick),
    .lo_tick(lo_tick));

  ccs_sequencer i_ccs_sequencer (.sys_clk(sys_clk), .reset_n(reset_n),
    .bus(bus), .rdata(rdata), .reference_input_tick(ref_tick),
    .lo_input_tick(lo_tick), .vco_ref_multiple(vco_ref_multiple),
    .state_machine_clock_tick(sm_tick), .offset_cal_clock_tick(off_tick),
    .i_cal_busy(i_busy), .q_cal_busy(q_busy), .i_cal_done(i_done),
    .q_cal_done(q_done), .i_gain_trim(i_gain), .q_gain_trim(q_gain),
    .phase_trim_magnitude(ph_mag), .phase_trim_polarity(ph_pol),
    .phase_trim_wide_range(ph_wide), .common_mode_select(cm_sel),
    .if_amp_pullup_enable(pu_en), .if_amp_pullup_strength(pu_str),
    .if_amp_bias_config(bias), .lo_port_termination(term),
    .inherent_sync(sync_flag));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic int lo_div(input logic [2:0] a, input logic [2:0] b);
    int f;
    case (a)
      3'b000: f = 1;
      3'b001: f = 2;
      3'b011: f = 4;
      3'b111: f = 8;
      default: f = 16;
    endcase
    return f << b;
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("mismatch %0t got %h expected %h", $time, got, exp);
      fails++;
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] w);
    @(posedge sys_clk);
    bus.we <= 1'b1;
    bus.addr <= a;
    bus.wdata <= w;
    @(posedge sys_clk);
    bus.we <= 1'b0;
    @(negedge sys_clk);
  endtask

  task automatic rd(input logic [6:0] a, output logic [15:0] r);
    @(posedge sys_clk);
    bus.re <= 1'b1;
    bus.addr <= a;
    @(posedge sys_clk);
    bus.re <= 1'b0;
    @(negedge sys_clk);
    r = rdata;
  endtask

  task automatic to_tick(output int n);
    n = 1;
    @(negedge sys_clk);
    while (tk !== 1'b1 && n < 400) begin
      @(negedge sys_clk);
      n++;
    end
  endtask

  // Skips the first, possibly partial, period after a change
  task automatic period(output int n);
    to_tick(n);
    to_tick(n);
    to_tick(n);
  endtask

  // Lets the two or three pipeline stages drain first
  task automatic quiet(output int c);
    c = 0;
    repeat (3) @(negedge sys_clk);
    repeat (40) begin
      @(negedge sys_clk);
      if (tk !== 1'b0) c++;
    end
  endtask

  task automatic wrap_up;
    if (fails == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // Hang guard; the whole run needs well under 10000 cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      wrap_up;
    end
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    seed = 32'h4bd9;
    bus = '0;
    reset_n = 1'b0;
    lo_present = 1'b0;
    slow = 1'b0;
    vco_ref_multiple = 1'b0;
    off_sel = 1'b0;
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(ADDR_CAL_DIV, v);
    chk(v, 16'h0808);
    rd(ADDR_GATE, v);
    chk(v, 16'h0500);
    @(negedge sys_clk);
    chk(rdata, 16'h0000);
    wr(7'h7F, 16'h0003);
    wr(7'h06, 16'h0100);
    wr(7'h7F, 16'h0000);
    rd(7'h06, v);
    chk(v, 16'h0100);
    // Write then read with no gap between strobes
    @(posedge sys_clk);
    bus.we <= 1'b1;
    bus.addr <= 7'h10;
    bus.wdata <= 16'hA5C3;
    @(posedge sys_clk);
    bus.we <= 1'b0;
    bus.re <= 1'b1;
    @(posedge sys_clk);
    bus.re <= 1'b0;
    @(negedge sys_clk);
    chk(rdata, 16'hA5C3);
    for (k = 0; k < 4; k++) begin
      d = $random(seed);
      v = d[15:0];
      wr(ADDR_GAIN, v | 16'h8080);
      chk({q_gain, i_gain}, v | 16'h8080);
      wr(ADDR_PHASE, v);
      chk({ph_pol, ph_mag}, v[15:9]);
      wr(ADDR_CAL_CTRL, v & 16'h8000);
      chk(ph_wide, v[15]);
      wr(ADDR_CM, v);
      chk({pu_str, cm_sel}, v[15:9]);
      wr(ADDR_PULLUP, v);
      chk(pu_en, v[6]);
      wr(ADDR_BIAS, v);
      chk(bias, v[1:0]);
      wr(ADDR_TERM, v);
      chk(term, v[1:0]);
      rd(ADDR_GAIN, v);
      chk(v, d[15:0] | 16'h8080);
    end
    wr(ADDR_CAL_CTRL, 16'h0000);
    // Internal path, last pass with a slow reference
    for (k = 0; k < 5; k++) begin
      slow <= (k == 4);
      wr(ADDR_CAL_DIV, 16'(k % 4));
      period(p);
      chk(16'(p), 16'((1 << (k % 4)) * (k == 4 ? 2 : 1)));
    end
    slow <= 1'b0;
    wr(ADDR_GATE, 16'h0000);
    quiet(p);
    chk(16'(p), 16'h0000);
    wr(ADDR_GATE, 16'h0500);
    // External path, every first-stage code
    lo_present <= 1'b1;
    for (k = 0; k < 8; k++) begin
      d = $random(seed) & 1;
      wr(ADDR_LO_DIV, 16'({k[2:0], d[2:0]}));
      wr(ADDR_LO_CLK, 16'h0001);
      quiet(p);
      chk(16'(p), 16'h0000);
      wr(ADDR_LO_CLK, 16'h00C1);
      period(p);
      chk(16'(p), 16'(lo_div(k[2:0], d[2:0])));
      wr(ADDR_STATUS, 16'hFFFF);
      rd(ADDR_STATUS, v);
      chk(v, 16'h0003);
    end
    wr(ADDR_LO_CLK, 16'h0000);
    lo_present <= 1'b0;
    // Offset-correction clock and channel runs
    wr(ADDR_CAL_DIV, 16'h0000);
    off_sel = 1'b1;
    wr(ADDR_OFFCAL, 16'h0003);
    period(p);
    chk(16'(p), 16'h0006);
    wr(ADDR_OFFCAL, 16'h0103);
    @(negedge sys_clk);
    chk({i_busy, q_busy}, 16'h0002);
    p = 2;
    while (i_done !== 1'b1 && p < 1000) begin
      @(negedge sys_clk);
      p++;
    end
    chk(16'(p >= CAL_STEPS * 6 - 6 && p <= CAL_STEPS * 6 + 12), 16'h1);
    chk({i_done, q_done, q_busy}, 16'h0004);
    wr(ADDR_OFFCAL, 16'h0203);
    @(negedge sys_clk);
    chk({i_busy, i_done, q_busy}, 16'h0001);
    wr(ADDR_CAL_CTRL, 16'h0100);
    @(negedge sys_clk);
    chk({q_busy, q_done}, 16'h0000);
    wr(ADDR_CAL_CTRL, 16'h0000);
    // Inherent synchronization conditions
    for (k = 0; k < 4; k++) begin
      case (k)
        0: v = 16'h0800;
        1: v = 16'h0C00;
        2: v = 16'h1000;
        default: v = 16'h0800;
      endcase
      @(posedge sys_clk);
      vco_ref_multiple <= (k != 3);
      wr(ADDR_OFFCAL, v);
      repeat (2) @(negedge sys_clk);
      chk(sync_flag, 16'(k == 0));
    end
    wrap_up;
  end
endmodule // ccs_sequencer_tb
`default_nettype wire
